// [dv/scan_distributor_point_controller_tb.sv]
// Self-checking bench for the scan and distributor point controller
`timescale 1ns/1ps
`default_nettype none
module scan_distributor_point_controller_tb import sdpc_pkg::*;;
   // Short flash half period keeps timed flash to 64 cycles
   localparam int HALF = 4;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic awvalid = 1'b0;
   logic awready;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hF;
   logic wvalid = 1'b0;
   logic wready;
   logic [1:0] bresp;
   logic bvalid;
   logic bready = 1'b0;
   logic [7:0] araddr = 8'h00;
   logic arvalid = 1'b0;
   logic arready;
   logic [31:0] rdata;
   logic [1:0] rresp;
   logic rvalid;
   logic rready = 1'b0;
   logic [47:0] scan_pins;
   logic [31:0] dist_pins;
   logic irq;
   logic [47:0] contacts = 48'h0;
   logic [4:0] lamp_sel = 5'h0;
   logic flip_clr = 1'b0;
   int lamp_flips;
   int fail_count = 0;
   int tests_run = 0;
   int cyc = 0;

   always #5 aclk = ~aclk;

   sdpc_controller #(.HALF_CYC(HALF)) dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .scan_input_point(scan_pins),
      .distributor_output_point(dist_pins), .irq(irq));

   sdpc_contacts_model far_side (.aclk(aclk), .contact_close(contacts),
      .lamp_drive(dist_pins), .lamp_sel(lamp_sel), .flip_clr(flip_clr),
      .scan_pins(scan_pins), .lamp_flips(lamp_flips));

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic check(input logic [47:0] got, input logic [47:0] exp);
      tests_run++;
      if (got !== exp) begin
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         fail_count++;
      end
   endtask

   // Both channels offered together; each released once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic got;
      logic [1:0] r;
      got = 1'b0;
      r = 2'h3;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!got) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            r = bresp;
            bready <= 1'b0;
            got = 1'b1;
         end
      end
      check({46'h0, r}, {46'h0, er});
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic got;
      logic [33:0] r;
      got = 1'b0;
      r = '1;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!got) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            r = {rresp, rdata};
            rready <= 1'b0;
            got = 1'b1;
         end
      end
      check({14'h0, r}, {14'h0, er, ed});
   endtask

   task automatic cmd(input sdpc_op_type op, input logic [7:0] pt);
      wr(SDPC_POINT_CMD, {21'h0, op, pt}, SDPC_RESP_OKAY);
      repeat (3) @(posedge aclk);
   endtask

   // Lamp flips seen by the far side over a window
   task automatic flips(input logic [4:0] idx, input int ncyc, input int lo, input int hi);
      @(posedge aclk);
      lamp_sel <= idx;
      flip_clr <= 1'b1;
      @(posedge aclk);
      flip_clr <= 1'b0;
      repeat (ncyc) @(posedge aclk);
      #1;
      check({47'h0, lamp_flips >= lo && lamp_flips <= hi}, 48'h1);
   endtask

   task automatic pins(input logic [31:0] e);
      @(posedge aclk);
      #1;
      check({16'h0, dist_pins}, {16'h0, e});
   endtask

   task automatic irq_is(input logic e);
      @(posedge aclk);
      #1;
      check({47'h0, irq}, {47'h0, e});
   endtask

   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         close_out();
      end
   end

   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 11; i++) begin
         rd(8'(4 * i), 32'h0, SDPC_RESP_OKAY);
      end
      rd(8'h2C, 32'h0, SDPC_RESP_SLVERR);
      wr(8'h2C, 32'h1, SDPC_RESP_SLVERR);
      wr(8'h11, 32'h1, SDPC_RESP_SLVERR);
      $display("test reset_map done");
      contacts <= 48'h9ABC_1234_5678;
      repeat (5) @(posedge aclk);
      rd(SDPC_SCAN_STATE_LO, 32'h1234_5678, SDPC_RESP_OKAY);
      rd(SDPC_SCAN_STATE_HI, 32'h0000_9ABC, SDPC_RESP_OKAY);
      rd(SDPC_EVT_LO, 32'h1234_5678, SDPC_RESP_OKAY);
      irq_is(1'b0);
      wr(SDPC_MASK_HI, 32'h0000_FFFF, SDPC_RESP_OKAY);
      irq_is(1'b1);
      wr(SDPC_EVT_HI, 32'hFFFF_FFFF, SDPC_RESP_OKAY);
      wr(SDPC_EVT_LO, 32'hFFFF_FFFF, SDPC_RESP_OKAY);
      irq_is(1'b0);
      $display("test scan_events done");
      cmd(SDPC_OP_INHIBIT, 8'd3);
      cmd(SDPC_OP_INHIBIT, 8'd40);
      rd(SDPC_INHIBIT_LO, 32'h8, SDPC_RESP_OKAY);
      rd(SDPC_INHIBIT_HI, 32'h100, SDPC_RESP_OKAY);
      contacts <= 48'h9ABC_1234_5670;
      repeat (5) @(posedge aclk);
      rd(SDPC_SCAN_STATE_LO, 32'h1234_5670, SDPC_RESP_OKAY);
      rd(SDPC_EVT_LO, 32'h0, SDPC_RESP_OKAY);
      cmd(SDPC_OP_ALLOW, 8'd3);
      rd(SDPC_INHIBIT_LO, 32'h0, SDPC_RESP_OKAY);
      rd(SDPC_INHIBIT_HI, 32'h100, SDPC_RESP_OKAY);
      wr(SDPC_MASK_LO, 32'h8, SDPC_RESP_OKAY);
      contacts <= 48'h9ABC_1234_5678;
      repeat (5) @(posedge aclk);
      rd(SDPC_EVT_LO, 32'h8, SDPC_RESP_OKAY);
      irq_is(1'b1);
      wr(SDPC_EVT_LO, 32'h8, SDPC_RESP_OKAY);
      irq_is(1'b0);
      $display("test inhibit_allow done");
      cmd(SDPC_OP_SET, 8'd0);
      pins(32'h1);
      cmd(SDPC_OP_SET, 8'd31);
      rd(SDPC_DIST_OUT, 32'h8000_0001, SDPC_RESP_OKAY);
      cmd(SDPC_OP_SET, 8'd32);
      cmd(SDPC_OP_REPEAT, 8'd33);
      cmd(SDPC_OP_SET, 8'd47);
      pins(32'h8000_0001);
      cmd(SDPC_OP_CLEAR, 8'd0);
      cmd(SDPC_OP_CLEAR, 8'd31);
      pins(32'h0);
      $display("test steady_drive done");
      cmd(SDPC_OP_REPEAT, 8'd5);
      flips(5'd5, 80, 19, 21);
      cmd(SDPC_OP_STEP, 8'd7);
      flips(5'd7, 100, 14, 17);
      flips(5'd7, 40, 0, 0);
      check({47'h0, dist_pins[7]}, 48'h0);
      flips(5'd5, 40, 9, 11);
      cmd(SDPC_OP_CLEAR, 8'd5);
      flips(5'd5, 20, 0, 0);
      pins(32'h0);
      $display("test flash done");
      cmd(SDPC_OP_SET, 8'd2);
      wr(SDPC_SELFTEST, 32'h1, SDPC_RESP_OKAY);
      repeat (3) @(posedge aclk);
      pins(32'h0);
      wr(SDPC_SELFTEST, 32'h0, SDPC_RESP_OKAY);
      repeat (3) @(posedge aclk);
      pins(32'h4);
      $display("test selftest done");
      close_out();
   end
endmodule
`default_nettype wire

// [dv/sdpc_contacts_model.sv]
// Contacts and lamps model standing on the far side of the point controller
`timescale 1ns/1ps
`default_nettype none
module sdpc_contacts_model (
   input wire logic aclk,
   input wire logic [47:0] contact_close,
   input wire logic [31:0] lamp_drive,
   input wire logic [4:0] lamp_sel,
   input wire logic flip_clr,
   output logic [47:0] scan_pins,
   output var int lamp_flips
);
   logic [31:0] lamp_prev;

   // Contacts are plain levels; nothing is ever released to float
   initial begin
      scan_pins = 48'h0;
      lamp_prev = 32'h0;
      lamp_flips = 0;
   end

   always @(posedge aclk) begin
      scan_pins <= contact_close;
      lamp_prev <= lamp_drive;
      if (flip_clr) begin
         lamp_flips <= 0;
      end else if (lamp_drive[lamp_sel] !== lamp_prev[lamp_sel]) begin
         lamp_flips <= lamp_flips + 1;
      end
   end
endmodule
`default_nettype wire

// [rtl/sdpc_controller.sv]
// Scan point sampler and distributor point driver with AXI4-Lite registers
//
// The AXI4-Lite register port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module sdpc_controller
   import sdpc_pkg::*;
#(
   parameter int HALF_CYC = SDPC_HALF_FLASH_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [SDPC_SCAN_POINTS-1:0] scan_input_point,
   output logic [SDPC_DIST_POINTS-1:0] distributor_output_point,
   output logic irq
);
   localparam int NS = SDPC_SCAN_POINTS;
   localparam int ND = SDPC_DIST_POINTS;

   // Scan inputs come from external contacts
   logic [NS-1:0] scan_meta_r, scan_sync_r, scan_prev_r;
   logic [NS-1:0] inhibit_r, evt_r, mask_r;
   logic [NS-1:0] evt_set, raw_scan;
   logic selftest_r;
   logic [NS-1:0] test_pattern_r;
   logic [ND-1:0] drive_out_r;
   sdpc_drv_type drv_r [ND];
   logic [4:0] halves_r [ND];
   logic phase, tick;

   // AXI write side
   logic aw_hold_r, w_hold_r;
   logic [7:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic wr_go;
   logic [7:0] rd_addr;

   sdpc_flash_timer #(.HALF_CYC(HALF_CYC)) u_timer (
      .aclk(aclk),
      .aresetn(aresetn),
      .phase(phase),
      .tick(tick)
   );

   assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
   assign s_axi_wready = !w_hold_r && !s_axi_bvalid;
   assign wr_go = aw_hold_r && w_hold_r && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_r <= 1'b0;
         awaddr_r <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_hold_r <= 1'b1;
         awaddr_r <= s_axi_awaddr;
      end else if (wr_go) begin
         aw_hold_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_hold_r <= 1'b0;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_hold_r <= 1'b1;
         wdata_r <= s_axi_wdata;
         wstrb_r <= s_axi_wstrb;
      end else if (wr_go) begin
         w_hold_r <= 1'b0;
      end
   end

   function automatic logic known_addr(input logic [7:0] a);
      known_addr = (a[1:0] == 2'h0) && (a <= SDPC_SELFTEST);
   endfunction

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= SDPC_RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= known_addr(awaddr_r) ? SDPC_RESP_OKAY : SDPC_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Decoded single-cycle write strobes; only full low bytes matter for commands
   logic cmd_wr, evt_lo_wr, evt_hi_wr;
   logic [7:0] cmd_pt;
   sdpc_op_type cmd_op;
   assign cmd_wr = wr_go && awaddr_r == SDPC_POINT_CMD && wstrb_r[0] && wstrb_r[1];
   assign evt_lo_wr = wr_go && awaddr_r == SDPC_EVT_LO;
   assign evt_hi_wr = wr_go && awaddr_r == SDPC_EVT_HI;
   assign cmd_pt = wdata_r[SDPC_CMD_PT_LSB +: 8];
   assign cmd_op = sdpc_op_type'(wdata_r[SDPC_CMD_OP_LSB +: 3]);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mask_r <= '0;
         selftest_r <= 1'b0;
      end else if (wr_go) begin
         if (awaddr_r == SDPC_MASK_LO) mask_r[31:0] <= wdata_r;
         if (awaddr_r == SDPC_MASK_HI) mask_r[NS-1:32] <= wdata_r[NS-33:0];
         if (awaddr_r == SDPC_SELFTEST) selftest_r <= wdata_r[0];
      end
   end

   // Two-stage synchroniser, then self-test may swap in an internal pattern
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         scan_meta_r <= '0;
         scan_sync_r <= '0;
      end else begin
         scan_meta_r <= scan_input_point;
         scan_sync_r <= scan_meta_r;
      end
   end

   // Walking pattern advances each flash tick while testing
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         test_pattern_r <= '0;
      end else if (!selftest_r) begin
         test_pattern_r <= '0;
      end else if (tick) begin
         test_pattern_r <= {test_pattern_r[NS-2:0], ~test_pattern_r[NS-1]};
      end
   end

   assign raw_scan = selftest_r ? test_pattern_r : scan_sync_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         scan_prev_r <= '0;
      end else begin
         scan_prev_r <= raw_scan;
      end
   end

   assign evt_set = (raw_scan ^ scan_prev_r) & ~inhibit_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         inhibit_r <= '0;
      end else if (cmd_wr && cmd_pt < 8'(NS)) begin
         if (cmd_op == SDPC_OP_INHIBIT) inhibit_r[cmd_pt[5:0]] <= 1'b1;
         if (cmd_op == SDPC_OP_ALLOW) inhibit_r[cmd_pt[5:0]] <= 1'b0;
      end
   end

   // Write-one-to-clear; a new event in the same cycle wins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         evt_r <= '0;
      end else begin
         evt_r <= (evt_r & ~({NS{1'b0}} | (evt_lo_wr ? {16'h0000, wdata_r} : '0)
                   | (evt_hi_wr ? {wdata_r[NS-33:0], 32'h0000_0000} : '0))) | evt_set;
      end
   end

   assign irq = |(evt_r & mask_r);

   genvar gi;
   generate
      for (gi = 0; gi < ND; gi++) begin : g_dist
         logic hit;
         assign hit = cmd_wr && cmd_pt == 8'(gi);
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               drv_r[gi] <= SDPC_DRV_CLEAR;
               halves_r[gi] <= 5'h00;
            end else if (hit && cmd_op == SDPC_OP_SET) begin
               drv_r[gi] <= SDPC_DRV_SET;
            end else if (hit && cmd_op == SDPC_OP_CLEAR) begin
               drv_r[gi] <= SDPC_DRV_CLEAR;
            end else if (hit && cmd_op == SDPC_OP_STEP) begin
               drv_r[gi] <= SDPC_DRV_TIMED;
               halves_r[gi] <= 5'(SDPC_TIMED_HALVES);
            end else if (hit && cmd_op == SDPC_OP_REPEAT) begin
               drv_r[gi] <= SDPC_DRV_CONT;
            end else if (drv_r[gi] == SDPC_DRV_TIMED && tick) begin
               if (halves_r[gi] == 5'h01) drv_r[gi] <= SDPC_DRV_CLEAR;
               halves_r[gi] <= halves_r[gi] - 5'h01;
            end
         end
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               drive_out_r[gi] <= 1'b0;
            end else begin
               case (drv_r[gi])
                  SDPC_DRV_SET: drive_out_r[gi] <= 1'b1;
                  SDPC_DRV_CLEAR: drive_out_r[gi] <= 1'b0;
                  SDPC_DRV_TIMED: drive_out_r[gi] <= phase;
                  SDPC_DRV_CONT: drive_out_r[gi] <= phase;
                  default: drive_out_r[gi] <= 1'b0;
               endcase
            end
         end
      end
   endgenerate

   // Self-test keeps pins quiet; the internal drive register stays readable
   assign distributor_output_point = selftest_r ? '0 : drive_out_r;

   // Read channel: one read at a time, answer one cycle after address taken
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_addr = s_axi_araddr;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= SDPC_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= known_addr(rd_addr) ? SDPC_RESP_OKAY : SDPC_RESP_SLVERR;
         case (rd_addr)
            SDPC_SCAN_STATE_LO: s_axi_rdata <= raw_scan[31:0];
            SDPC_SCAN_STATE_HI: s_axi_rdata <= {16'h0000, raw_scan[NS-1:32]};
            SDPC_INHIBIT_LO: s_axi_rdata <= inhibit_r[31:0];
            SDPC_INHIBIT_HI: s_axi_rdata <= {16'h0000, inhibit_r[NS-1:32]};
            SDPC_DIST_OUT: s_axi_rdata <= drive_out_r;
            SDPC_EVT_LO: s_axi_rdata <= evt_r[31:0];
            SDPC_EVT_HI: s_axi_rdata <= {16'h0000, evt_r[NS-1:32]};
            SDPC_MASK_LO: s_axi_rdata <= mask_r[31:0];
            SDPC_MASK_HI: s_axi_rdata <= {16'h0000, mask_r[NS-1:32]};
            SDPC_SELFTEST: s_axi_rdata <= {31'h0000_0000, selftest_r};
            default: s_axi_rdata <= SDPC_RESET_ZERO;
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Checks
   property p_inhibit_blocks;
      @(posedge aclk) disable iff (!aresetn)
         inhibit_r[3] && !$past(evt_r[3]) |-> !evt_r[3] || !$past(inhibit_r[3]);
   endproperty
   a_inhibit_blocks: assert property (p_inhibit_blocks)
      else $error("event on inhibited point");
   property p_allow_clears;
      @(posedge aclk) disable iff (!aresetn)
         cmd_wr && cmd_op == SDPC_OP_ALLOW && cmd_pt == 8'h03 |=> !inhibit_r[3];
   endproperty
   a_allow_clears: assert property (p_allow_clears) else $error("allow kept inhibit");
   property p_inhibit_sets;
      @(posedge aclk) disable iff (!aresetn)
         cmd_wr && cmd_op == SDPC_OP_INHIBIT && cmd_pt == 8'h28 |=> inhibit_r[40];
   endproperty
   a_inhibit_sets: assert property (p_inhibit_sets) else $error("inhibit not set");
   property p_set_drives;
      @(posedge aclk) disable iff (!aresetn)
         cmd_wr && cmd_op == SDPC_OP_SET && cmd_pt == 8'h00 && !selftest_r
         ##1 !cmd_wr |=> distributor_output_point[0];
   endproperty
   a_set_drives: assert property (p_set_drives) else $error("set not driven");
   property p_clear_drives;
      @(posedge aclk) disable iff (!aresetn)
         cmd_wr && cmd_op == SDPC_OP_CLEAR && cmd_pt == 8'h00 ##1 !cmd_wr
         |=> !drive_out_r[0];
   endproperty
   a_clear_drives: assert property (p_clear_drives) else $error("clear not driven");
   property p_step_ends;
      @(posedge aclk) disable iff (!aresetn)
         drv_r[7] == SDPC_DRV_TIMED && halves_r[7] == 5'h01 && tick && !cmd_wr
         |=> drv_r[7] == SDPC_DRV_CLEAR;
   endproperty
   a_step_ends: assert property (p_step_ends) else $error("timed flash did not end");
   property p_cont_holds;
      @(posedge aclk) disable iff (!aresetn)
         drv_r[5] == SDPC_DRV_CONT && !cmd_wr |=> drv_r[5] == SDPC_DRV_CONT;
   endproperty
   a_cont_holds: assert property (p_cont_holds) else $error("continuous flash stopped");
   property p_high_points_ignored;
      @(posedge aclk) disable iff (!aresetn)
         cmd_wr && cmd_pt >= 8'h20 |=> $stable(drv_r[0]) && $stable(drv_r[31]);
   endproperty
   a_high_points_ignored: assert property (p_high_points_ignored)
      else $error("order to absent point changed output");
   property p_selftest_quiet;
      @(posedge aclk) disable iff (!aresetn) selftest_r |-> distributor_output_point == '0;
   endproperty
   a_selftest_quiet: assert property (p_selftest_quiet) else $error("pins driven in test");
   property p_evt_on_change;
      @(posedge aclk) disable iff (!aresetn)
         raw_scan[3] != scan_prev_r[3] && !inhibit_r[3] |=> evt_r[3];
   endproperty
   a_evt_on_change: assert property (p_evt_on_change) else $error("transition lost");
   c_step: cover property (@(posedge aclk) cmd_wr && cmd_op == SDPC_OP_STEP);
   c_irq: cover property (@(posedge aclk) $rose(irq));
   c_inhibit: cover property (@(posedge aclk) cmd_wr && cmd_op == SDPC_OP_INHIBIT);
endmodule
`default_nettype wire

// [rtl/sdpc_flash_timer.sv]
// Flash phase generator with half-period tick
`timescale 1ns/1ps
`default_nettype none
module sdpc_flash_timer
   import sdpc_pkg::*;
#(
   parameter int HALF_CYC = SDPC_HALF_FLASH_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   output logic phase,
   output logic tick
);
   // Elaboration check: a half period needs at least two clocks
   if (HALF_CYC < 2) begin : g_bad_half
      $error("HALF_CYC must be at least 2");
   end

   logic [31:0] cnt_r;

   // Counts the system clock for a half-duty flash phase
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_r <= 32'h0000_0000;
         phase <= 1'b0;
      end else if (cnt_r == 32'(HALF_CYC - 1)) begin
         cnt_r <= 32'h0000_0000;
         phase <= ~phase;
      end else begin
         cnt_r <= cnt_r + 32'h0000_0001;
      end
   end

   assign tick = (cnt_r == 32'(HALF_CYC - 1));
endmodule
`default_nettype wire

// [shared/sdpc_pkg.sv]
// Package: constants, register map and types for the scan/distributor point controller
//
// Summary of operation
// - Inhibit order stops event reporting for one scan point; sampling continues.
// - Allow order resumes event reporting for one scan point, clearing its inhibit.
// - Status query returns each scan point's sampled state and inhibit flag.
// - Set order drives distributor output steady active; clear drives it steady inactive.
// - Timed flash alternates the output for 8 seconds, then it rests steady.
// - Continuous flash alternates until replaced; four drive states per point.
// - Distributor outputs exist for points 0-31; drive orders to 32-47 do nothing (inhibit and allow still act on scan points 32-47).
// - Self-test exercises only on-board circuitry, never the external connections.
// - Provides 48 scan inputs and 32 distributor outputs, addressed by number.
package sdpc_pkg;
   localparam int SDPC_SCAN_POINTS = 48;
   localparam int SDPC_DIST_POINTS = 32;
   localparam int SDPC_CLK_HZ = 100_000_000;
   localparam int SDPC_FLASH_PERIOD_MS = 1000;
   localparam int SDPC_TIMED_FLASH_S = 8;
   // Half a flash period in clock cycles
   localparam int SDPC_HALF_FLASH_CYC = (SDPC_CLK_HZ / 1000) * SDPC_FLASH_PERIOD_MS / 2;
   localparam int SDPC_TIMED_HALVES = SDPC_TIMED_FLASH_S * 1000 / (SDPC_FLASH_PERIOD_MS / 2);

   // Register byte offsets
   localparam logic [7:0] SDPC_SCAN_STATE_LO = 8'h00;
   localparam logic [7:0] SDPC_SCAN_STATE_HI = 8'h04;
   localparam logic [7:0] SDPC_INHIBIT_LO = 8'h08;
   localparam logic [7:0] SDPC_INHIBIT_HI = 8'h0C;
   localparam logic [7:0] SDPC_POINT_CMD = 8'h10;
   localparam logic [7:0] SDPC_DIST_OUT = 8'h14;
   localparam logic [7:0] SDPC_EVT_LO = 8'h18;
   localparam logic [7:0] SDPC_EVT_HI = 8'h1C;
   localparam logic [7:0] SDPC_MASK_LO = 8'h20;
   localparam logic [7:0] SDPC_MASK_HI = 8'h24;
   localparam logic [7:0] SDPC_SELFTEST = 8'h28;

   // Command register fields
   localparam int SDPC_CMD_PT_LSB = 0;
   localparam int SDPC_CMD_OP_LSB = 8;
   localparam logic [31:0] SDPC_RESET_ZERO = 32'h0000_0000;
   localparam logic [1:0] SDPC_RESP_OKAY = 2'h0;
   localparam logic [1:0] SDPC_RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      SDPC_OP_NONE = 3'b000,
      SDPC_OP_SET = 3'b001,
      SDPC_OP_CLEAR = 3'b010,
      SDPC_OP_STEP = 3'b011,
      SDPC_OP_REPEAT = 3'b100,
      SDPC_OP_INHIBIT = 3'b101,
      SDPC_OP_ALLOW = 3'b110
   } sdpc_op_type;

   typedef enum logic [1:0] {
      SDPC_DRV_CLEAR = 2'b00,
      SDPC_DRV_SET = 2'b01,
      SDPC_DRV_TIMED = 2'b10,
      SDPC_DRV_CONT = 2'b11
   } sdpc_drv_type;
endpackage
